// ===== inc/ppb_pkg.sv
// Shared constants, bus carriers and state layout for the protector self-check block.
package ppb_pkg;

	// ==========================================================================
	// Sizes and timing
	localparam int NCELL = 6;                    // Monitored cell channels.
	localparam int NGPIO = 8;                    // Monitored thermistor channels.
	localparam int CLK_MHZ = 40;                 // Core clock rate.
	localparam int SETTLE_NS = 1000;             // Least settle time of a stimulus, ns.
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int PARITY_PERIOD_NS = 10000;     // Background parity check period, ns.
	localparam int PARITY_CYC = (PARITY_PERIOD_NS * CLK_MHZ) / 1000;

	// ==========================================================================
	// Register byte offsets
	localparam logic [7:0] OFS_VCTRL = 8'h00;    // voltage_protector_control
	localparam logic [7:0] OFS_TCTRL = 8'h04;    // temp_protector_control
	localparam logic [7:0] OFS_VTHR  = 8'h08;    // Over/under voltage thresholds.
	localparam logic [7:0] OFS_TTHR  = 8'h0C;    // Over/under temperature thresholds.
	localparam logic [7:0] OFS_NUM   = 8'h10;    // Active channel counts.
	localparam logic [7:0] OFS_DIAG  = 8'h14;    // protector_diag_control
	localparam logic [7:0] OFS_STATA = 8'h18;    // protector_fault_status_a
	localparam logic [7:0] OFS_STATB = 8'h1C;    // protector_fault_status_b
	localparam logic [7:0] OFS_FLAGS = 8'h20;    // Channel fault flags.
	localparam logic [7:0] OFS_DACRD = 8'h24;    // Threshold readback and engine state.

	// ==========================================================================
	// Field positions
	localparam int CTRL_GO_BIT   = 2;            // Go command, write only.
	localparam int CTRL_LOCK_LSB = 3;            // Channel lock field.
	localparam int NUM_GPIO_LSB  = 4;            // Thermistor count minus one.
	localparam int DIAG_KEEP_BIT = 0;            // selftest_keep_faults
	localparam int DIAG_PIN_BIT  = 1;            // Fault pin enable.
	localparam int DIAG_VINJ_BIT = 2;            // Corrupt latched voltage config, write only.
	localparam int DIAG_TINJ_BIT = 3;            // Corrupt latched temperature config, write only.
	localparam int DIAG_DSEL_LSB = 4;            // Threshold DAC route select.
	localparam int DIAG_DEN_BIT  = 6;            // Threshold DAC route enable.
	localparam int A_VPAR = 0;                   // voltage_cfg_parity_err
	localparam int A_TPAR = 1;                   // temp_cfg_parity_err
	localparam int B_OVCOMP = 0;                 // over_volt_comparator_err
	localparam int B_UVCOMP = 1;                 // under_volt_comparator_err
	localparam int B_OTCOMP = 2;                 // over_temp_comparator_err
	localparam int B_UTCOMP = 3;                 // under_temp_comparator_err
	localparam int B_VPATH  = 4;                 // voltage_path_err
	localparam int B_TPATH  = 5;                 // temp_path_err
	localparam int B_ABORT  = 6;                 // selftest_aborted_flag
	localparam int F_UV = 0;                     // under_volt_channel_flags
	localparam int F_OV = 8;                     // over_volt_channel_flags
	localparam int F_UT = 16;                    // under_temp_channel_flags
	localparam int F_OT = 24;                    // over_temp_channel_flags

	// ==========================================================================
	// Encodings and reset values
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_RR = 2'h1;       // Round robin.
	localparam logic [1:0] MODE_BIST = 2'h2;     // Self-test.
	localparam logic [1:0] DSEL_OV = 2'h0;
	localparam logic [1:0] DSEL_UV = 2'h1;
	localparam logic [1:0] DSEL_OT = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] RST_THR_HI = 8'hC0;
	localparam logic [7:0] RST_THR_LO = 8'h40;
	localparam logic [2:0] RST_NUM_CELL = 3'h5;
	localparam logic [2:0] RST_NUM_GPIO = 3'h7;
	localparam logic RST_PIN_EN = 1'b1;

	// ==========================================================================
	// Carriers
	typedef struct packed {
		logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
		logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr; logic rready;
	} ppb_axi_req_t;
	typedef struct packed {
		logic awready; logic wready; logic bvalid; logic [1:0] bresp;
		logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
	} ppb_axi_rsp_t;
	typedef struct packed {
		logic hi_cmp;             // Over comparator of the protector under test.
		logic lo_cmp;             // Under comparator of the protector under test.
		logic fault_pin_sense_n;  // Level read back from the fault pin.
	} ppb_ana_in_t;
	typedef struct packed {
		logic cmp_en; logic stim_hi; logic stim_lo;
		logic [NCELL-1:0] cell_sw_open; logic [NGPIO-1:0] gpio_pullup;
		logic dac_route_en; logic [1:0] dac_route_sel;
	} ppb_ana_out_t;
	typedef enum logic [2:0] {
		ENG_IDLE, ENG_CMP_HI, ENG_CMP_LO, ENG_PATH_SET, ENG_PATH_CHK, ENG_FORCE_CHK
	} ppb_eng_t;
	typedef struct packed {
		ppb_axi_rsp_t rsp; ppb_ana_out_t ana;
		logic aw_held; logic w_held; logic [7:0] awaddr; logic [31:0] wdata; logic [3:0] wstrb;
		logic [1:0] v_mode; logic [3:0] v_lock; logic [1:0] t_mode; logic [2:0] t_lock;
		logic [7:0] ov_thr; logic [7:0] uv_thr; logic [7:0] ot_thr; logic [7:0] ut_thr;
		logic [2:0] num_cell; logic [2:0] num_gpio; logic keep; logic pin_en;
		logic [1:0] stat_a; logic [6:0] stat_b;
		logic [NCELL-1:0] uv_f; logic [NCELL-1:0] ov_f; logic [NGPIO-1:0] ut_f; logic [NGPIO-1:0] ot_f;
		logic [20:0] v_lat; logic [20:0] t_lat; logic v_par; logic t_par; logic v_on; logic t_on;
		logic [8:0] par_cnt; ppb_eng_t eng; logic tgt; logic [2:0] ch; logic [7:0] wait_cnt;
		logic fault_n;
	} ppb_state_t;

endpackage

// ===== hdl/ppb_protector_check.sv
// Protector configuration parity check, threshold DAC routing and comparator self-test engine.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ppb_protector_check (
	input  wire logic                 aclk,            // Core clock, 40 MHz.
	input  wire logic                 aresetn,         // Synchronous reset, active low.
	input  wire ppb_pkg::ppb_axi_req_t axi_req,        // AXI4-Lite master to slave.
	output var ppb_pkg::ppb_axi_rsp_t axi_rsp,         // AXI4-Lite slave to master.
	input  wire ppb_pkg::ppb_ana_in_t  ana_in,         // Comparator and pin readback.
	output var ppb_pkg::ppb_ana_out_t ana_out,         // Stimulus and DAC routing.
	output logic                      fault_out_pin_n  // Fault pin, low on fault.
);
	import ppb_pkg::*;

	ppb_state_t       s;
	ppb_state_t       n;
	logic             go_v, go_t, done, pin_ok, par_tick, do_wr, do_rd, wr_ok, rd_ok;
	logic [7:0]       lo_fl, hi_fl, ese_lo, ese_hi, ecl_lo, ecl_hi, nxt_bit;
	logic [2:0]       last_ch;
	logic [31:0]      wd, wm, rd, hclr_f;
	logic [1:0]       set_a, hclr_a;
	logic [6:0]       set_b, hclr_b;

	// ==========================================================================
	// Helpers
	function automatic logic [31:0] strb_mask(input logic [3:0] st);
		strb_mask = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
	endfunction

	function automatic logic [7:0] ch_bit(input logic [2:0] c);
		ch_bit = 8'h01 << c;
	endfunction

	// Scales a voltage threshold code by four fifths, as the DAC readback shows it.
	function automatic logic [9:0] dac_scale(input logic [7:0] thr);
		dac_scale = 10'(({2'h0, thr} * 10'h4) / 10'h5);
	endfunction

	// Packs the settings that one protector latches when it is started.
	function automatic logic [20:0] cfg_word(input logic [7:0] hi, input logic [7:0] lo,
		input logic [1:0] md, input logic [2:0] cnt);
		cfg_word = {hi, lo, md, cnt};
	endfunction

	assign axi_rsp = s.rsp;
	assign ana_out = s.ana;
	assign fault_out_pin_n = s.fault_n;

	// ==========================================================================
	// Next-state logic: engine, bus, go commands, parity, flag merge.
	always_comb begin
		n = s;
		go_v = 1'b0;
		go_t = 1'b0;
		ese_lo = 8'h00;
		ese_hi = 8'h00;
		ecl_lo = 8'h00;
		ecl_hi = 8'h00;
		set_a = 2'h0;
		set_b = 7'h00;
		hclr_a = 2'h0;
		hclr_b = 7'h00;
		hclr_f = 32'h0000_0000;
		lo_fl = s.tgt ? s.ut_f : {2'h0, s.uv_f};
		hi_fl = s.tgt ? s.ot_f : {2'h0, s.ov_f};
		last_ch = s.tgt ? s.num_gpio : ((s.num_cell > 3'(NCELL - 1)) ? 3'(NCELL - 1) : s.num_cell);
		nxt_bit = ch_bit(3'(s.ch + 3'h1));
		pin_ok = !s.pin_en || !ana_in.fault_pin_sense_n;
		done = (s.wait_cnt == 8'h00);
		par_tick = (s.par_cnt == 9'h000);
		wd = s.wdata;
		wm = strb_mask(s.wstrb);
		do_wr = s.aw_held && s.w_held && !s.rsp.bvalid;
		do_rd = axi_req.arvalid && s.rsp.arready;
		wr_ok = 1'b1;
		rd_ok = 1'b1;
		rd = 32'h0000_0000;

		// Self-test engine; each step waits one settle time before it judges.
		if (!done) begin
			n.wait_cnt = s.wait_cnt - 8'h01;
		end else begin
			case (s.eng)
				ENG_IDLE: begin
				end
				ENG_CMP_HI: begin
					if (!ana_in.hi_cmp) begin
						set_b[s.tgt ? B_OTCOMP : B_OVCOMP] = 1'b1;
					end
					n.ana.stim_hi = 1'b0;
					n.ana.stim_lo = 1'b1;
					n.eng = ENG_CMP_LO;
					n.wait_cnt = 8'(SETTLE_CYC);
				end
				ENG_CMP_LO: begin
					if (!ana_in.lo_cmp) begin
						set_b[s.tgt ? B_UTCOMP : B_UVCOMP] = 1'b1;
					end
					n.ana.stim_lo = 1'b0;
					if ((|lo_fl) || (|hi_fl)) begin
						set_b[B_ABORT] = 1'b1;
						n.ana.cmp_en = 1'b0;
						n.eng = ENG_IDLE;
					end else begin
						n.ch = 3'h0;
						n.ana.cell_sw_open = s.tgt ? '0 : NCELL'(ch_bit(3'h0));
						n.ana.gpio_pullup = s.tgt ? ch_bit(3'h0) : '0;
						n.eng = ENG_PATH_SET;
						n.wait_cnt = 8'(SETTLE_CYC);
					end
				end
				ENG_PATH_SET: begin
					if (ana_in.lo_cmp) begin
						ese_lo = ch_bit(s.ch);
					end
					n.eng = ENG_PATH_CHK;
					n.wait_cnt = 8'(SETTLE_CYC);
				end
				ENG_PATH_CHK: begin
					if (!(lo_fl[s.ch] && pin_ok)) begin
						set_b[s.tgt ? B_TPATH : B_VPATH] = 1'b1;
					end
					if (!s.keep) begin
						ecl_lo = ch_bit(s.ch);
					end
					n.wait_cnt = 8'(SETTLE_CYC);
					if (s.ch == last_ch) begin
						n.ana.cell_sw_open = '0;
						n.ana.gpio_pullup = '0;
						n.ch = 3'h0;
						ese_hi = ch_bit(3'h0);
						n.eng = ENG_FORCE_CHK;
					end else begin
						n.ch = s.ch + 3'h1;
						n.ana.cell_sw_open = s.tgt ? '0 : NCELL'(nxt_bit);
						n.ana.gpio_pullup = s.tgt ? nxt_bit : '0;
						n.eng = ENG_PATH_SET;
					end
				end
				ENG_FORCE_CHK: begin
					if (!(hi_fl[s.ch] && pin_ok)) begin
						set_b[s.tgt ? B_TPATH : B_VPATH] = 1'b1;
					end
					if (!s.keep) begin
						ecl_hi = ch_bit(s.ch);
					end
					if (s.ch == last_ch) begin
						n.ana.cmp_en = 1'b0;
						n.eng = ENG_IDLE;
					end else begin
						n.ch = s.ch + 3'h1;
						ese_hi = nxt_bit;
						n.wait_cnt = 8'(SETTLE_CYC);
					end
				end
				default: begin
					n.eng = ENG_IDLE;
				end
			endcase
		end

		// Write channels are taken independently; the write lands once both are held.
		if (axi_req.awvalid && s.rsp.awready) begin
			n.aw_held = 1'b1;
			n.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s.rsp.wready) begin
			n.w_held = 1'b1;
			n.wdata = axi_req.wdata;
			n.wstrb = axi_req.wstrb;
		end
		if (s.rsp.bvalid && axi_req.bready) begin
			n.rsp.bvalid = 1'b0;
		end
		if (do_wr) begin
			case (s.awaddr)
				OFS_VCTRL: if (s.wstrb[0]) begin
					n.v_mode = wd[1:0];
					n.v_lock = wd[CTRL_LOCK_LSB +: 4];
					go_v = wd[CTRL_GO_BIT];
				end
				OFS_TCTRL: if (s.wstrb[0]) begin
					n.t_mode = wd[1:0];
					n.t_lock = wd[CTRL_LOCK_LSB +: 3];
					go_t = wd[CTRL_GO_BIT];
				end
				OFS_VTHR: begin
					n.ov_thr = s.wstrb[0] ? wd[7:0] : s.ov_thr;
					n.uv_thr = s.wstrb[1] ? wd[15:8] : s.uv_thr;
				end
				OFS_TTHR: begin
					n.ot_thr = s.wstrb[0] ? wd[7:0] : s.ot_thr;
					n.ut_thr = s.wstrb[1] ? wd[15:8] : s.ut_thr;
				end
				OFS_NUM: if (s.wstrb[0]) begin
					n.num_cell = wd[2:0];
					n.num_gpio = wd[NUM_GPIO_LSB +: 3];
				end
				OFS_DIAG: if (s.wstrb[0]) begin
					n.keep = wd[DIAG_KEEP_BIT];
					n.pin_en = wd[DIAG_PIN_BIT];
					n.ana.dac_route_sel = wd[DIAG_DSEL_LSB +: 2];
					n.ana.dac_route_en = wd[DIAG_DEN_BIT];
					n.v_lat[0] = s.v_lat[0] ^ wd[DIAG_VINJ_BIT];
					n.t_lat[0] = s.t_lat[0] ^ wd[DIAG_TINJ_BIT];
				end
				OFS_STATA: hclr_a = wd[1:0] & wm[1:0];
				OFS_STATB: hclr_b = wd[6:0] & wm[6:0];
				OFS_FLAGS: hclr_f = wd & wm;
				OFS_DACRD: begin
				end
				default: wr_ok = 1'b0;
			endcase
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.rsp.bvalid = 1'b1;
			n.rsp.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		n.rsp.awready = !n.aw_held && !n.rsp.bvalid;
		n.rsp.wready = !n.w_held && !n.rsp.bvalid;

		// A go latches the configuration; a self-test go (re)starts the engine unless the other protector is under test, and any
		// other go to the protector under test ends the running test.
		if (go_v) begin
			n.v_on = (n.v_mode != MODE_OFF);
			n.v_lat = cfg_word(n.ov_thr, n.uv_thr, n.v_mode, n.num_cell);
			n.v_par = ^cfg_word(n.ov_thr, n.uv_thr, n.v_mode, n.num_cell);
		end
		if (go_t) begin
			n.t_on = (n.t_mode != MODE_OFF);
			n.t_lat = cfg_word(n.ot_thr, n.ut_thr, n.t_mode, n.num_gpio);
			n.t_par = ^cfg_word(n.ot_thr, n.ut_thr, n.t_mode, n.num_gpio);
		end
		if ((go_v && n.v_mode == MODE_BIST && (s.eng == ENG_IDLE || !s.tgt)) ||
			(go_t && n.t_mode == MODE_BIST && (s.eng == ENG_IDLE || s.tgt))) begin
			n.tgt = !(go_v && n.v_mode == MODE_BIST && (s.eng == ENG_IDLE || !s.tgt));
			n.eng = ENG_CMP_HI;
			n.ch = 3'h0;
			n.ana.cmp_en = 1'b1;
			n.ana.stim_hi = 1'b1;
			n.ana.stim_lo = 1'b0;
			n.ana.cell_sw_open = '0;
			n.ana.gpio_pullup = '0;
			n.wait_cnt = 8'(SETTLE_CYC);
		end else if (s.eng != ENG_IDLE && ((go_v && !s.tgt) || (go_t && s.tgt))) begin
			n.eng = ENG_IDLE;
			n.ana.cmp_en = 1'b0;
			n.ana.stim_hi = 1'b0;
			n.ana.stim_lo = 1'b0;
			n.ana.cell_sw_open = '0;
			n.ana.gpio_pullup = '0;
		end

		// Background parity recheck of the latched copies.
		n.par_cnt = par_tick ? 9'(PARITY_CYC - 1) : s.par_cnt - 9'h001;
		if (par_tick && s.v_on && ((^s.v_lat) != s.v_par)) begin
			set_a[A_VPAR] = 1'b1;
		end
		if (par_tick && s.t_on && ((^s.t_lat) != s.t_par)) begin
			set_a[A_TPAR] = 1'b1;
		end

		// Sticky flags: hardware set wins over a clear in the same cycle.
		n.stat_a = (s.stat_a & ~hclr_a) | set_a;
		n.stat_b = (s.stat_b & ~hclr_b) | set_b;
		n.uv_f = (s.uv_f & ~hclr_f[F_UV +: NCELL] & (s.tgt ? '1 : ~ecl_lo[NCELL-1:0]))
			| (s.tgt ? '0 : ese_lo[NCELL-1:0]);
		n.ov_f = (s.ov_f & ~hclr_f[F_OV +: NCELL] & (s.tgt ? '1 : ~ecl_hi[NCELL-1:0]))
			| (s.tgt ? '0 : ese_hi[NCELL-1:0]);
		n.ut_f = (s.ut_f & ~hclr_f[F_UT +: NGPIO] & (s.tgt ? ~ecl_lo : '1)) | (s.tgt ? ese_lo : '0);
		n.ot_f = (s.ot_f & ~hclr_f[F_OT +: NGPIO] & (s.tgt ? ~ecl_hi : '1)) | (s.tgt ? ese_hi : '0);
		n.fault_n = !(n.pin_en && (|{n.uv_f, n.ov_f, n.ut_f, n.ot_f}));

		// Read channel: the answer is registered at the same edge that takes the address.
		case (axi_req.araddr)
			OFS_VCTRL: rd = {25'h0, s.v_lock, 1'b0, s.v_mode};
			OFS_TCTRL: rd = {26'h0, s.t_lock, 1'b0, s.t_mode};
			OFS_VTHR: rd = {16'h0, s.uv_thr, s.ov_thr};
			OFS_TTHR: rd = {16'h0, s.ut_thr, s.ot_thr};
			OFS_NUM: rd = {25'h0, s.num_gpio, 1'b0, s.num_cell};
			OFS_DIAG: rd = {25'h0, s.ana.dac_route_en, s.ana.dac_route_sel, 2'h0, s.pin_en, s.keep};
			OFS_STATA: rd = {30'h0, s.stat_a};
			OFS_STATB: rd = {25'h0, s.stat_b};
			OFS_FLAGS: rd = {s.ot_f, s.ut_f, 2'h0, s.ov_f, 2'h0, s.uv_f};
			OFS_DACRD: begin
				rd[15:12] = {s.t_on, s.v_on, s.tgt, s.eng != ENG_IDLE};
				case (s.ana.dac_route_sel)
					DSEL_OV: rd[9:0] = dac_scale(s.ov_thr);
					DSEL_UV: rd[9:0] = dac_scale(s.uv_thr);
					DSEL_OT: rd[9:0] = {2'h0, s.ot_thr};
					default: rd[9:0] = {2'h0, s.ut_thr};
				endcase
			end
			default: rd_ok = 1'b0;
		endcase
		if (s.rsp.rvalid && axi_req.rready) begin
			n.rsp.rvalid = 1'b0;
		end
		if (do_rd) begin
			n.rsp.rvalid = 1'b1;
			n.rsp.rdata = rd;
			n.rsp.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		n.rsp.arready = !n.rsp.rvalid;
	end

	// ==========================================================================
	// State register; reset loads constants only.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.rsp.awready <= 1'b1;
			s.rsp.wready <= 1'b1;
			s.rsp.arready <= 1'b1;
			s.ov_thr <= RST_THR_HI;
			s.uv_thr <= RST_THR_LO;
			s.ot_thr <= RST_THR_HI;
			s.ut_thr <= RST_THR_LO;
			s.num_cell <= RST_NUM_CELL;
			s.num_gpio <= RST_NUM_GPIO;
			s.pin_en <= RST_PIN_EN;
			s.par_cnt <= 9'(PARITY_CYC - 1);
			s.fault_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ==========================================================================
	// Checks on the behaviour above.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence sq_cmp_start;
		s.eng == ENG_CMP_HI && s.ana.cmp_en && s.ana.stim_hi && s.wait_cnt == 8'(SETTLE_CYC);
	endsequence
	sequence sq_hi_miss;
		s.eng == ENG_CMP_HI && done && !ana_in.hi_cmp && !s.tgt;
	endsequence

	property p_vpar;
		par_tick && s.v_on && ((^s.v_lat) != s.v_par) |=> s.stat_a[A_VPAR];
	endproperty
	a_vpar: assert property (p_vpar) else $error("voltage parity error not raised");
	property p_tpar;
		par_tick && s.t_on && ((^s.t_lat) != s.t_par) |=> s.stat_a[A_TPAR];
	endproperty
	a_tpar: assert property (p_tpar) else $error("temperature parity error not raised");
	property p_vstart;
		go_v && n.v_mode == MODE_BIST && s.eng == ENG_IDLE |=> sq_cmp_start ##1 !done;
	endproperty
	a_vstart: assert property (p_vstart) else $error("self-test did not start");
	property p_ovcmp;
		sq_hi_miss |=> s.stat_b[B_OVCOMP];
	endproperty
	a_ovcmp: assert property (p_ovcmp) else $error("over comparator error not flagged");
	property p_end_off;
		s.eng == ENG_FORCE_CHK && done && s.ch == last_ch && !go_v && !go_t
			|=> !s.ana.cmp_en && s.eng == ENG_IDLE;
	endproperty
	a_end_off: assert property (p_end_off) else $error("comparators left on at end");
	property p_vstop;
		go_v && n.v_mode == MODE_RR && s.eng != ENG_IDLE && !s.tgt |=> s.eng == ENG_IDLE;
	endproperty
	a_vstop: assert property (p_vstop) else $error("go did not end self-test");
	property p_abort;
		s.eng == ENG_CMP_LO && done && (|lo_fl || |hi_fl) && !go_v && !go_t
			|=> s.stat_b[B_ABORT] && s.eng == ENG_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("pre-existing fault did not abort");
	property p_keep;
		s.keep && s.eng == ENG_PATH_CHK && done && lo_fl[s.ch] && hclr_f == 32'h0 |=> |lo_fl;
	endproperty
	a_keep: assert property (p_keep) else $error("fault flag cleared with keep set");
	property p_pin;
		s.pin_en && (|{s.uv_f, s.ov_f, s.ut_f, s.ot_f}) |-> !fault_out_pin_n;
	endproperty
	a_pin: assert property (p_pin) else $error("fault pin not asserted");
	property p_sticky;
		s.stat_b[B_ABORT] && !(do_wr && s.awaddr == OFS_STATB) |=> s.stat_b[B_ABORT];
	endproperty
	a_sticky: assert property (p_sticky) else $error("abort flag lost without clear");

endmodule // ppb_protector_check
`default_nettype wire

// ===== verification/ppb_analog_model.sv
// Behavioural comparators and fault pin readback facing the protector self-check block.
`timescale 1ns/1ps
`default_nettype none
module ppb_analog_model (
	input  wire logic                 cmp_stuck,       // Holds the over comparator dead.
	input  wire ppb_pkg::ppb_ana_out_t ana_out,        // Stimulus from the block.
	input  wire logic                 fault_out_pin_n, // Fault pin as driven.
	output var ppb_pkg::ppb_ana_in_t  ana_in           // Comparator and pin readback.
);
	import ppb_pkg::*;
	// ==========================================================================
	// Comparators
	// An unpowered comparator never trips, so a run with the comparators off cannot pass.
	always_comb begin
		ana_in.hi_cmp = ana_out.cmp_en & ana_out.stim_hi & ~cmp_stuck;
		ana_in.lo_cmp = ana_out.cmp_en & (ana_out.stim_lo | (|ana_out.cell_sw_open)
			| (|ana_out.gpio_pullup));
		ana_in.fault_pin_sense_n = fault_out_pin_n;
	end
endmodule // ppb_analog_model
`default_nettype wire

// ===== verification/protector_parity_and_bist_tb.sv
// Self-checking bench for the protector self-check block.
`timescale 1ns/1ps
`default_nettype none
module protector_parity_and_bist_tb;
	import ppb_pkg::*;
	// ==========================================================================
	// Signals
	logic         aclk = 1'b0;
	logic         aresetn = 1'b0;
	logic         cmp_stuck = 1'b0;
	ppb_axi_req_t req = '0;
	ppb_axi_rsp_t rsp;
	ppb_ana_in_t  ana_in;
	ppb_ana_out_t ana_out;
	logic         pin_n;
	logic [31:0]  rd;
	logic [1:0]   rr;
	logic [5:0]   sw_last;
	int           pin_lows = 0;
	int           order_bad = 0;
	int           err_count = 0;
	int           num_checks = 0;
	// The clock inverts every half period of 12.5 ns.
	always #12.5 aclk = ~aclk;
	ppb_protector_check i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.ana_in(ana_in), .ana_out(ana_out), .fault_out_pin_n(pin_n));
	ppb_analog_model i_ana (.cmp_stuck(cmp_stuck), .ana_out(ana_out), .fault_out_pin_n(pin_n),
		.ana_in(ana_in));
	// Pin activity and the order of opened cell switches are logged each cycle.
	always @(posedge aclk) begin
		if (pin_n === 1'b0) pin_lows++;
		if (ana_out.cell_sw_open != '0) begin
			if (ana_out.cell_sw_open < sw_last) order_bad++;
			sw_last = ana_out.cell_sw_open;
		end
	end
	// ==========================================================================
	// Reporting and bus tasks
	task automatic close_out();
		if (err_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic hang();
		err_count++;
		close_out();
	endtask
	// Address and data go out together; each is dropped at the edge that takes it.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				rr = rsp.bresp;
				req.bready <= 1'b0;
				return;
			end
		end
		hang();
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				rd = rsp.rdata;
				rr = rsp.rresp;
				req.rready <= 1'b0;
				return;
			end
		end
		hang();
	endtask
	// Starts a self-test and polls the busy bit until the engine is idle again.
	task automatic bist(input logic [7:0] ofs, input logic [31:0] diag);
		wr(OFS_DIAG, diag);
		wr(ofs, 32'h6);
		for (int i = 0; i < 600; i++) begin
			rd_reg(OFS_DACRD);
			if (rd[12] === 1'b0) return;
		end
		hang();
	endtask
	// ==========================================================================
	// Scenarios
	task automatic t_reset();
		rd_reg(OFS_VTHR);
		chk(rd, {16'h0, RST_THR_LO, RST_THR_HI});
		rd_reg(8'h30);
		chk({rd[29:0], rr}, {30'h0, RESP_SLVERR});
		wr(8'h30, 32'h0);
		chk({30'h0, rr}, {30'h0, RESP_SLVERR});
	endtask
	task automatic t_dac();
		logic [9:0] exp [4];
		exp = '{({2'b0, RST_THR_HI} * 10'd4) / 10'd5, ({2'b0, RST_THR_LO} * 10'd4) / 10'd5,
			{2'b0, RST_THR_HI}, {2'b0, RST_THR_LO}};
		wr(OFS_VCTRL, 32'h7);
		wr(OFS_TCTRL, 32'h7);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_DIAG, 32'h42 | (32'(i) << 4));
			rd_reg(OFS_DACRD);
			chk({22'h0, rd[9:0]}, {22'h0, exp[i]});
			chk({29'h0, ana_out.dac_route_en, ana_out.dac_route_sel}, 32'h4 | 32'(i));
		end
	endtask
	// Both latched copies are corrupted, then the protectors are stopped before clearing.
	task automatic t_parity();
		wr(OFS_VCTRL, 32'h5);
		wr(OFS_TCTRL, 32'h5);
		wr(OFS_DIAG, 32'hE);
		repeat (PARITY_CYC + 20) @(posedge aclk);
		rd_reg(OFS_STATA);
		chk(rd, 32'h3);
		wr(OFS_VCTRL, 32'h4);
		wr(OFS_TCTRL, 32'h4);
		wr(OFS_STATA, 32'h3);
		rd_reg(OFS_STATA);
		chk(rd, 32'h0);
	endtask
	task automatic t_bist();
		for (int t = 0; t < 2; t++) begin
			pin_lows = 0;
			sw_last = '0;
			bist(t ? OFS_TCTRL : OFS_VCTRL, 32'h2);
			rd_reg(OFS_STATB);
			chk(rd, 32'h0);
			rd_reg(OFS_FLAGS);
			chk(rd, 32'h0);
			chk({30'h0, ana_out.cmp_en, pin_lows > 0}, 32'h1);
			chk({26'h0, sw_last}, t ? 32'h0 : 32'h20);
		end
		chk(32'(order_bad), 32'h0);
	endtask
	// A dead over comparator, then a kept-fault run followed by a run that must abort.
	task automatic t_fail();
		cmp_stuck <= 1'b1;
		bist(OFS_VCTRL, 32'h2);
		cmp_stuck <= 1'b0;
		rd_reg(OFS_STATB);
		chk(rd, 32'h1 << B_OVCOMP);
		wr(OFS_STATB, 32'h7F);
		bist(OFS_VCTRL, 32'h3);
		rd_reg(OFS_FLAGS);
		chk({rd[31:1], pin_n}, 32'h3F3E);
		bist(OFS_VCTRL, 32'h3);
		rd_reg(OFS_STATB);
		chk(rd, 32'h1 << B_ABORT);
		wr(OFS_FLAGS, 32'hFFFFFFFF);
		wr(OFS_STATB, 32'h7F);
	endtask
	task automatic t_go();
		for (int t = 0; t < 2; t++) begin
			wr(t ? OFS_TCTRL : OFS_VCTRL, 32'h6);
			repeat (50) @(posedge aclk);
			rd_reg(OFS_DACRD);
			chk({31'h0, rd[12]}, 32'h1);
			wr(t ? OFS_TCTRL : OFS_VCTRL, 32'h5);
			rd_reg(OFS_DACRD);
			// The temperature protector stays on from its earlier self-test go.
			chk({29'h0, rd[15:14], rd[12]}, t ? 32'h4 : 32'h6);
			wr(t ? OFS_TCTRL : OFS_VCTRL, 32'h4);
		end
	endtask
	// ==========================================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_dac();
		t_parity();
		t_bist();
		t_fail();
		t_go();
		close_out();
	end
endmodule // protector_parity_and_bist_tb
`default_nettype wire
